// >>> hw/dtmf_host_pkg.sv
// types shared by the dtmf host port design
// assumes the constants header is compiled alongside
package dtmf_host_pkg;
	typedef struct packed {
		logic [3:0] data;
		logic       oe;
	} nibble_drive_s;
	typedef enum logic [1:0] {
		BURST_IDLE,
		BURST_TONE,
		BURST_PAUSE
	} burst_state_e;
endpackage

// >>> hw/dtmf_host_params.svh
// constants of the dtmf host port
// Behaviour
// [RULE_01] tone output floats while the transmit output enable bit is zero
// [RULE_02] interrupt mode pulls the line low after a tone sent or received
// [RULE_03] interrupt line is open drain: pull low or release only
// [RULE_04] call progress mode drives the line with the squared filter signal
// [RULE_05] host selects call progress mode through a control bit
// [RULE_06] host qualifies chip select with its address strobe, never tied low
// [RULE_07] write pin is direction select or write strobe by bus style
// [RULE_08] host toggles data strobe or read pin only during accesses
// [RULE_09] register select chooses the register, held valid for the access
// [RULE_10] timing derives from a 3.579545 MHz reference, crystal or clock
// [RULE_11] external clock on crystal input accepted, crystal output left open
// [RULE_12] transmitter and receiver power down independently by register
// [RULE_13] burst mode times tone burst and pause with internal counters
// [RULE_14] data bus floats when deselected or strobe inactive
// [RULE_15] both powered down: stop oscillator, float interrupt, tone and data
// [RULE_16] interrupt held until the host reads status
`ifndef DTMF_HOST_PARAMS_SVH
`define DTMF_HOST_PARAMS_SVH
`define REF_FREQ_HZ     3579545
`define SYS_FREQ_HZ     100000000
// control register a bits
`define CRA_TRANSMIT_OUTPUT_ENABLE_BIT_BIT    0
`define CRA_CP_BIT      1
`define CRA_IRQEN_BIT   2
`define CRA_RSEL_BIT    3
// control register b bits
`define CRB_BURST_BIT   0
`define CRB_RXPD_BIT    1
// status bits
`define ST_IRQ_BIT      0
`define ST_TXE_BIT      1
`define ST_RXF_BIT      2
`define BURST_MS        51
`define BURST_CYC       (`BURST_MS * 100000)
`define NIB_ZERO        4'h0
`endif

// >>> hw/ref_clock_div.sv
// reference-rate enable generator from the system clock
// assumes crystal_in, when used, is sampled synchronously
`timescale 1ns/1ps
`default_nettype none
`include "dtmf_host_params.svh"
module ref_clock_div
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// control
	input  wire logic run,
	input  wire logic use_ext,
	input  wire logic ext_in,
	// enable out
	output logic      tick
);
	// fractional accumulator gives exact average reference rate
	logic [31:0] acc_q;
	logic [31:0] acc_d;
	logic [32:0] sum;
	logic        ext_q;
	logic        tick_q;
	assign sum   = {1'b0, acc_q} + 33'(`REF_FREQ_HZ);
	assign acc_d = (sum >= 33'(`SYS_FREQ_HZ)) ? 32'(sum - 33'(`SYS_FREQ_HZ)) : sum[31:0];
	assign tick  = tick_q;
	always_ff @(posedge clk)
	begin
		if (!rst_n || !run)
		begin
			acc_q  <= 32'h0;
			ext_q  <= 1'b0;
			tick_q <= 1'b0;
		end
		else
		begin
			acc_q  <= acc_d;
			ext_q  <= ext_in;
			tick_q <= use_ext ? (ext_in & ~ext_q) : (sum >= 33'(`SYS_FREQ_HZ)); // RULE_10 RULE_11
		end
	end
endmodule // ref_clock_div
`default_nettype wire

// >>> hw/dtmf_host_port.sv
// host port of the dtmf transceiver: registers, strobes, interrupt_or_progress_out, power down
// assumes all pins synchronous to SYS_CLK; analog paths are outside
`timescale 1ns/1ps
`default_nettype none
`include "dtmf_host_params.svh"
module dtmf_host_port
	import dtmf_host_pkg::*;
#(
	parameter int BURST_CYCLES = `BURST_CYC
)
(
	// clock and reset
	input  wire logic       SYS_CLK,
	input  wire logic       RESET_N,
	// bus style: 1 = separate read/write strobes
	input  wire logic       SEP_STROBES,
	// host bus
	input  wire logic       CS_N,
	input  wire logic       REGISTER_SELECT_LINE,
	input  wire logic       DATA_STROBE_OR_READ,
	input  wire logic       WRITE_OR_DIR,
	input  wire logic [3:0] HOST_DATA_NIBBLE_IN,
	output logic      [3:0] HOST_DATA_NIBBLE_OUT,
	output logic            HOST_DATA_NIBBLE_OE,
	// timing source
	input  wire logic       EXT_CLOCK_SEL,
	input  wire logic       CRYSTAL_IN,
	output logic            CRYSTAL_OUT,
	output logic            CRYSTAL_OUT_OE,
	output logic            REF_TICK,
	// tone path
	input  wire logic       RX_DIGIT_VALID,
	input  wire logic [3:0] RX_DIGIT,
	input  wire logic       CP_FILTER_LEVEL,
	output logic            TONE_ENABLE,
	output logic            TONE_OE,
	output logic      [3:0] TX_DIGIT,
	// interrupt / call progress, open drain
	output logic            INTERRUPT_OR_PROGRESS_OUT,
	output logic            INTERRUPT_OR_PROGRESS_OE,
	// power state
	output logic            TX_POWERED,
	output logic            RX_POWERED,
	output logic            OSC_RUN
);
	logic [3:0]   cra_q;
	logic [3:0]   crb_q;
	logic [3:0]   txd_q;
	logic [3:0]   rxd_q;
	logic         rxf_q;
	logic         txe_q;
	logic         irq_q;
	logic         act_q;
	logic [3:0]   rdata_q;
	logic         rd_oe_q;
	burst_state_e bst_q;
	logic [31:0]  bcnt_q;
	logic         tx_go_q;
	nibble_drive_s drv;

	function automatic logic access_edge(input logic cur, input logic prev);
		access_edge = cur & ~prev;
	endfunction

	// strobe decoding per bus style
	wire sel       = ~CS_N; // RULE_06
	wire strobe_on = SEP_STROBES ? (~DATA_STROBE_OR_READ | ~WRITE_OR_DIR) : DATA_STROBE_OR_READ; // RULE_08
	wire is_write  = SEP_STROBES ? ~WRITE_OR_DIR : ~WRITE_OR_DIR & DATA_STROBE_OR_READ; // RULE_07
	wire is_read   = SEP_STROBES ? ~DATA_STROBE_OR_READ : WRITE_OR_DIR & DATA_STROBE_OR_READ; // RULE_07
	wire access    = sel & strobe_on;
	wire acc_start = access_edge(access, act_q);
	wire wr_start  = acc_start & is_write;
	wire rd_start  = acc_start & is_read;
	// register select: 0 = data, 1 = control/status
	wire wr_data   = wr_start & ~REGISTER_SELECT_LINE; // RULE_09
	wire wr_ctrl   = wr_start & REGISTER_SELECT_LINE; // RULE_09
	wire rd_status = rd_start & REGISTER_SELECT_LINE; // RULE_09
	wire rd_data   = rd_start & ~REGISTER_SELECT_LINE;
	// control b reached by writing with the select bit of control a set
	wire wr_cra    = wr_ctrl & ~cra_q[`CRA_RSEL_BIT];
	wire wr_crb    = wr_ctrl & cra_q[`CRA_RSEL_BIT];

	wire tx_on     = cra_q[`CRA_TRANSMIT_OUTPUT_ENABLE_BIT_BIT]; // RULE_12
	wire rx_on     = ~crb_q[`CRB_RXPD_BIT]; // RULE_12
	wire all_down  = ~tx_on & ~rx_on; // RULE_15
	wire cp_mode   = cra_q[`CRA_CP_BIT]; // RULE_05
	wire irq_mode  = cra_q[`CRA_IRQEN_BIT] & ~cp_mode;
	wire burst_on  = crb_q[`CRB_BURST_BIT];
	wire tx_done   = (bst_q == BURST_TONE && bcnt_q == 32'h0)
	               | (!burst_on && tx_go_q);
	wire rx_event  = RX_DIGIT_VALID & rx_on;
	wire [3:0] status_nib = {1'b0, rxf_q, txe_q, irq_q};
	wire [3:0] rd_value   = REGISTER_SELECT_LINE ? status_nib : rxd_q;

	// bus drives only while selected and its read strobe is active
	assign drv.data = rdata_q;
	assign drv.oe   = rd_oe_q & sel & is_read & ~all_down; // RULE_14 RULE_15
	assign HOST_DATA_NIBBLE_OUT = drv.data;
	assign HOST_DATA_NIBBLE_OE  = drv.oe;

	ref_clock_div u_div
	(
		.clk     (SYS_CLK),
		.rst_n   (RESET_N),
		.run     (~all_down), // RULE_15
		.use_ext (EXT_CLOCK_SEL), // RULE_11
		.ext_in  (CRYSTAL_IN),
		.tick    (REF_TICK)
	);
	// crystal output left undriven in external clock mode
	assign CRYSTAL_OUT    = ~CRYSTAL_IN;
	assign CRYSTAL_OUT_OE = ~EXT_CLOCK_SEL & ~all_down; // RULE_11 RULE_15

	assign TONE_ENABLE = tx_on & (!burst_on || bst_q == BURST_TONE);
	assign TONE_OE     = tx_on; // RULE_01
	assign TX_DIGIT    = txd_q;
	assign TX_POWERED  = tx_on;
	assign RX_POWERED  = rx_on;
	assign OSC_RUN     = ~all_down;
	// open drain: output value is always low, only the enable moves
	assign INTERRUPT_OR_PROGRESS_OUT = 1'b0; // RULE_03
	assign INTERRUPT_OR_PROGRESS_OE  = all_down ? 1'b0 : // RULE_15
		cp_mode ? ~CP_FILTER_LEVEL : (irq_mode & irq_q); // RULE_04 RULE_02

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			cra_q   <= `NIB_ZERO;
			crb_q   <= `NIB_ZERO;
			txd_q   <= `NIB_ZERO;
			act_q   <= 1'b0;
			rdata_q <= `NIB_ZERO;
			rd_oe_q <= 1'b0;
		end
		else
		begin
			act_q <= access;
			if (wr_cra)
				cra_q <= HOST_DATA_NIBBLE_IN;
			if (wr_crb)
				crb_q <= HOST_DATA_NIBBLE_IN;
			if (wr_data)
				txd_q <= HOST_DATA_NIBBLE_IN;
			if (rd_start)
				rdata_q <= rd_value;
			rd_oe_q <= access & is_read;
		end
	end

	// burst timer: tone then equal pause, no host timing needed
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			bst_q   <= BURST_IDLE;
			bcnt_q  <= 32'h0;
			tx_go_q <= 1'b0;
		end
		else
		begin
			tx_go_q <= wr_data & tx_on;
			unique case (bst_q)
				BURST_IDLE:
					if (wr_data && tx_on && burst_on)
					begin
						bst_q  <= BURST_TONE; // RULE_13
						bcnt_q <= 32'(BURST_CYCLES - 1);
					end
				BURST_TONE:
					if (!tx_on)
						bst_q <= BURST_IDLE;
					else if (bcnt_q == 32'h0)
					begin
						bst_q  <= BURST_PAUSE; // RULE_13
						bcnt_q <= 32'(BURST_CYCLES - 1);
					end
					else
						bcnt_q <= bcnt_q - 32'h1;
				BURST_PAUSE:
					if (bcnt_q == 32'h0 || !tx_on)
						bst_q <= BURST_IDLE;
					else
						bcnt_q <= bcnt_q - 32'h1;
			endcase
		end
	end

	// status flags: a new event wins over the clearing read
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			rxf_q <= 1'b0;
			txe_q <= 1'b0;
			irq_q <= 1'b0;
			rxd_q <= `NIB_ZERO;
		end
		else
		begin
			if (rx_event)
				rxd_q <= RX_DIGIT;
			rxf_q <= rx_event | (rxf_q & ~rd_data);
			txe_q <= tx_done | (txe_q & ~rd_status);
			irq_q <= tx_done | rx_event | (irq_q & ~rd_status); // RULE_16 RULE_02
		end
	end
endmodule // dtmf_host_port
`default_nettype wire

// >>> tb/dtmf_host_checker.sv
// pin-level checks of the dtmf host port
// bound to dtmf_host_port, sees its ports only, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dtmf_host_checker
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	// host bus
	input wire logic SEP_STROBES,
	input wire logic CS_N,
	input wire logic DATA_STROBE_OR_READ,
	input wire logic WRITE_OR_DIR,
	input wire logic HOST_DATA_NIBBLE_OE,
	// timing source
	input wire logic EXT_CLOCK_SEL,
	input wire logic CRYSTAL_IN,
	input wire logic CRYSTAL_OUT,
	input wire logic CRYSTAL_OUT_OE,
	// outputs
	input wire logic TONE_ENABLE,
	input wire logic TONE_OE,
	input wire logic INTERRUPT_OR_PROGRESS_OUT,
	input wire logic INTERRUPT_OR_PROGRESS_OE,
	input wire logic TX_POWERED,
	input wire logic RX_POWERED,
	input wire logic OSC_RUN
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	a_od_pull_low: assert property (INTERRUPT_OR_PROGRESS_OUT == 1'b0)
		else $error("open drain line driven high");
	a_tone_float: assert property (!TX_POWERED |-> !TONE_OE)
		else $error("tone driven while disabled");
	a_cs_float: assert property (CS_N |-> !HOST_DATA_NIBBLE_OE)
		else $error("data driven while deselected");
	a_ds_float: assert property (!SEP_STROBES && !DATA_STROBE_OR_READ |-> !HOST_DATA_NIBBLE_OE)
		else $error("data driven with strobe low");
	a_rd_float: assert property (SEP_STROBES && DATA_STROBE_OR_READ |-> !HOST_DATA_NIBBLE_OE)
		else $error("data driven with read high");
	a_write_dir: assert property (!WRITE_OR_DIR |-> !HOST_DATA_NIBBLE_OE)
		else $error("data driven during a write");
	a_all_down: assert property (!TX_POWERED && !RX_POWERED |->
		!OSC_RUN && !INTERRUPT_OR_PROGRESS_OE && !TONE_OE && !HOST_DATA_NIBBLE_OE)
		else $error("pins active while all powered down");
	a_ext_open: assert property (EXT_CLOCK_SEL |-> !CRYSTAL_OUT_OE)
		else $error("crystal output driven in external mode");
	a_xtal_loop: assert property (CRYSTAL_OUT_OE |-> CRYSTAL_OUT == !CRYSTAL_IN)
		else $error("crystal output not inverting");
endmodule // dtmf_host_checker
bind dtmf_host_port dtmf_host_checker chk_u (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
	.SEP_STROBES(SEP_STROBES), .CS_N(CS_N), .DATA_STROBE_OR_READ(DATA_STROBE_OR_READ),
	.WRITE_OR_DIR(WRITE_OR_DIR), .HOST_DATA_NIBBLE_OE(HOST_DATA_NIBBLE_OE),
	.EXT_CLOCK_SEL(EXT_CLOCK_SEL), .CRYSTAL_IN(CRYSTAL_IN), .CRYSTAL_OUT(CRYSTAL_OUT),
	.CRYSTAL_OUT_OE(CRYSTAL_OUT_OE), .TONE_ENABLE(TONE_ENABLE), .TONE_OE(TONE_OE),
	.INTERRUPT_OR_PROGRESS_OUT(INTERRUPT_OR_PROGRESS_OUT),
	.INTERRUPT_OR_PROGRESS_OE(INTERRUPT_OR_PROGRESS_OE), .TX_POWERED(TX_POWERED),
	.RX_POWERED(RX_POWERED), .OSC_RUN(OSC_RUN));
`default_nettype wire

// >>> tb/host_bus_model.sv
// host processor side of the parallel port, either bus style
// each call ends with chip select high, so the port sees an idle cycle between calls
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
(
	// clock and read side
	input  wire logic       clk,
	input  wire logic [3:0] dout,
	input  wire logic       oe,
	// bus pins
	output logic            sep,
	output logic            cs_n,
	output logic            rs,
	output logic            data_strobe_or_read,
	output logic            wr_dir,
	output logic      [3:0] din
);
	initial
	begin
		{sep, cs_n, rs, data_strobe_or_read, wr_dir, din} = 9'h0E0;
	end
	// one access: chip select only inside the cycle, strobe idle otherwise
	task acc(input logic s, input logic r, input logic w, input logic [3:0] d,
		output logic [3:0] q, output logic o);
		@(posedge clk);
		sep <= s;
		cs_n <= 1'b0;
		rs <= r;
		data_strobe_or_read <= s ? w : 1'b1;
		wr_dir <= !w;
		din <= d;
		@(posedge clk);
		#1;
		q = dout;
		o = oe;
		@(posedge clk);
		cs_n <= 1'b1;
		data_strobe_or_read <= s;
		wr_dir <= 1'b1;
		din <= ~d;
		#1;
	endtask
endmodule // host_bus_model
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench of the dtmf host port
// the host model drives the bus; the bench drives tone and clock inputs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       sep, cs_n, rs, data_strobe_or_read, wr_dir, oe, irq_oe, tone_oe, txp, rxp, osc, tick;
	logic       ext_sel = 1'b0;
	logic       xin = 1'b0;
	logic       rxv = 1'b0;
	logic       cpl = 1'b1;
	logic       xo, xo_oe, o, ten, irq_out;
	logic [3:0] rxd = 4'h0;
	logic [3:0] din, dout, txd, q;
	int         fail_count = 0;
	int         n_checks = 0;
	int         n;
	always #5 clk = ~clk;
	host_bus_model host_u (.clk(clk), .dout(dout), .oe(oe), .sep(sep), .cs_n(cs_n), .rs(rs),
		.data_strobe_or_read(data_strobe_or_read), .wr_dir(wr_dir), .din(din));
	dtmf_host_port #(.BURST_CYCLES(20)) dut_u (.SYS_CLK(clk), .RESET_N(rst_n),
		.SEP_STROBES(sep), .CS_N(cs_n), .REGISTER_SELECT_LINE(rs), .DATA_STROBE_OR_READ(data_strobe_or_read),
		.WRITE_OR_DIR(wr_dir), .HOST_DATA_NIBBLE_IN(din), .HOST_DATA_NIBBLE_OUT(dout),
		.HOST_DATA_NIBBLE_OE(oe), .EXT_CLOCK_SEL(ext_sel), .CRYSTAL_IN(xin), .CRYSTAL_OUT(xo),
		.CRYSTAL_OUT_OE(xo_oe), .REF_TICK(tick), .RX_DIGIT_VALID(rxv), .RX_DIGIT(rxd),
		.CP_FILTER_LEVEL(cpl), .TONE_ENABLE(ten), .TONE_OE(tone_oe), .TX_DIGIT(txd),
		.INTERRUPT_OR_PROGRESS_OUT(irq_out), .INTERRUPT_OR_PROGRESS_OE(irq_oe), .TX_POWERED(txp),
		.RX_POWERED(rxp), .OSC_RUN(osc));
	task chk(input logic [3:0] seen, input logic [3:0] want);
		n_checks++;
		if (seen !== want)
		begin
			fail_count++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task wr(input logic r, input logic [3:0] d);
		host_u.acc(1'b0, r, 1'b1, d, q, o);
	endtask
	task t_reset;
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk({1'b0, txp, rxp, osc}, 4'h3);
		chk({1'b0, tone_oe, irq_oe, oe}, 4'h0);
		chk({3'h0, irq_out}, 4'h0);
	endtask
	task t_tone;
		wr(1'b1, 4'h1);
		chk({3'h0, tone_oe}, 4'h1);
		wr(1'b1, 4'h0);
		chk({3'h0, tone_oe}, 4'h0);
	endtask
	task t_irq;
		wr(1'b1, 4'h5);
		wr(1'b0, 4'h7);
		repeat (2) @(posedge clk);
		#1;
		chk({3'h0, irq_oe}, 4'h1);
		chk(txd, 4'h7);
		host_u.acc(1'b1, 1'b1, 1'b0, 4'h0, q, o);
		chk(q & 4'h3, 4'h3);
		chk({3'h0, o}, 4'h1);
		chk({3'h0, irq_oe}, 4'h0);
	endtask
	task t_rx;
		@(posedge clk);
		rxd <= 4'h9;
		rxv <= 1'b1;
		@(posedge clk);
		rxv <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({3'h0, irq_oe}, 4'h1);
		host_u.acc(1'b0, 1'b0, 1'b0, 4'h0, q, o);
		chk(q, 4'h9);
		host_u.acc(1'b0, 1'b1, 1'b0, 4'h0, q, o);
		chk({3'h0, irq_oe}, 4'h0);
	endtask
	task t_cp;
		wr(1'b1, 4'h2);
		for (int lv = 0; lv < 2; lv++)
		begin
			@(posedge clk);
			cpl <= lv[0];
			repeat (2) @(posedge clk);
			#1;
			chk({3'h0, irq_oe}, {3'h0, !lv[0]});
		end
	endtask
	task t_ext;
		@(posedge clk);
		ext_sel <= 1'b1;
		n = 0;
		for (int i = 0; i < 40; i++)
		begin
			@(posedge clk);
			if (i % 4 == 0)
				xin <= ~xin;
			#1;
			n += tick;
		end
		chk(n[3:0], 4'h5);
		chk({3'h0, xo_oe}, 4'h0);
		@(posedge clk);
		ext_sel <= 1'b0;
		n = 0;
		repeat (1000)
		begin
			@(posedge clk);
			#1;
			n += tick;
		end
		chk({3'h0, n inside {35, 36}}, 4'h1);
	endtask
	task t_burst;
		wr(1'b1, 4'hD);
		wr(1'b1, 4'h1);
		wr(1'b0, 4'h3);
		chk({3'h0, ten}, 4'h1);
		n = 0;
		while (!irq_oe && n < 60)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({3'h0, n inside {[16:22]}}, 4'h1);
		chk({3'h0, ten}, 4'h0);
		if (n == 60)
			print_verdict();
	endtask
	task t_down;
		t_reset();
		wr(1'b1, 4'h8);
		wr(1'b1, 4'h2);
		chk({1'b0, txp, rxp, osc}, 4'h0);
		host_u.acc(1'b0, 1'b0, 1'b0, 4'h0, q, o);
		chk({3'h0, o}, 4'h0);
	endtask
	initial
	begin
		t_reset();
		t_tone();
		t_irq();
		t_rx();
		t_cp();
		t_ext();
		t_reset();
		t_burst();
		t_down();
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
